/* verilog/bus_cycle_pkg.sv */
`default_nettype none
package bus_cycle_pkg;
  // cycle status code {select, status1, status0}
  localparam logic [2:0] CODE_MEM_WRITE = 3'h1;
  localparam logic [2:0] CODE_MEM_READ = 3'h2;
  localparam logic [2:0] CODE_OPFETCH = 3'h3;
  localparam logic [2:0] CODE_IO_WRITE = 3'h5;
  localparam logic [2:0] CODE_IO_READ = 3'h6;
  localparam logic [2:0] CODE_INT_ACK = 3'h7;
  localparam logic [1:0] CODE_HALT_STATUS = 2'h0;
  localparam int SELECT_BIT = 2;
  localparam int STATUS1_BIT = 1;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [15:0] ADDR_RESET = 16'h0000;

  typedef enum logic [2:0] {
    KIND_MEM_WRITE = 3'h1,
    KIND_MEM_READ = 3'h2,
    KIND_OPFETCH = 3'h3,
    KIND_IO_WRITE = 3'h5,
    KIND_IO_READ = 3'h6,
    KIND_INT_ACK = 3'h7
  } cycle_kind_t;

  typedef struct packed {
    cycle_kind_t kind;
    logic [15:0] addr;
    logic [7:0] wdata;
  } cycle_req_t;

  typedef struct packed {
    logic [7:0] rdata;
    logic [2:0] kind;
  } cycle_done_t;
endpackage : bus_cycle_pkg
`default_nettype wire

/* verilog/reset_sync.sv */
`timescale 1ns/1ns
`default_nettype none
module reset_sync (
  input wire logic clk,
  input wire logic rst_in_n,
  output logic rst_out_n
);
  logic meta;
  always_ff @(posedge clk or negedge rst_in_n) begin
    if (!rst_in_n) begin
      meta <= 1'b0;
      rst_out_n <= 1'b0;
    end else begin
      meta <= 1'b1;
      rst_out_n <= meta;
    end
  end
endmodule : reset_sync
`default_nettype wire

/* verilog/tri_out.sv */
`timescale 1ns/1ns
`default_nettype none
module tri_out #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] next_value,
  input wire logic next_enable,
  output logic [WIDTH-1:0] value,
  output logic enable
);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      value <= '0;
      enable <= 1'b0;
    end else begin
      value <= next_value;
      enable <= next_enable;
    end
  end
endmodule : tri_out
`default_nettype wire

/* verilog/bus_cycle.sv */
// How it works
// R1: high address outputs carry address bits 15..8, or the port number for I/O.
// R2: high address, read and write strobes float in hold, halt, reset.
// R3: first clock state puts low eight address bits on shared lines.
// R4: second, third states carry data; device drives only on writes.
// R5: address latch strobe pulses in first state, low address stable around it.
// R6: address latch strobe is always driven, never floated.
// R7: peripherals latch low address on the address latch strobe.
// R8: status code memory write 001, memory read 010.
// R9: status code I/O write 101, I/O read 110.
// R10: status code opcode fetch 011, interrupt acknowledge 111.
// R11: halt drives status bits low, select floats; hold/reset float select.
// R12: status bit 1 high for reads, low for writes, before strobes.
// R13: select and status set at cycle start, held till cycle end.
// R14: active-low read strobe asks addressed device to drive data.
// R15: active-low write strobe marks valid write data on bus.
// R16: write data stays valid through the strobe's rising edge.
// R17: addressed device raises ready when prepared to transfer.
// R18: while ready low, insert whole wait clocks; finish after ready high. The code ignores ready in opcode fetch and interrupt acknowledge cycles.
// R19: ready sampled in second state; waits hold all bus outputs steady.
`timescale 1ns/1ns
`default_nettype none
module bus_cycle (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic HOLD_MODE,
  input wire logic HALT_MODE,
  input wire logic REQ_VALID,
  input wire bus_cycle_pkg::cycle_req_t REQ,
  output logic REQ_READY,
  output logic DONE_VALID,
  output bus_cycle_pkg::cycle_done_t DONE,
  input wire logic READY,
  output logic [7:0] HIGH_ADDRESS_BYTE,
  output logic HIGH_ADDRESS_BYTE_OE,
  input wire logic [7:0] SHARED_LOW_ADDR_DATA_IN,
  output logic [7:0] SHARED_LOW_ADDR_DATA_OUT,
  output logic SHARED_LOW_ADDR_DATA_OE,
  output logic ADDR_LATCH_STROBE,
  output logic MEM_IO_SELECT,
  output logic MEM_IO_SELECT_OE,
  output logic CYCLE_STATUS_BIT1,
  output logic CYCLE_STATUS_BIT0,
  output logic READ_STROBE_N,
  output logic WRITE_STROBE_N,
  output logic STROBES_OE
);
  import bus_cycle_pkg::*;

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic rst_n;
  // two flops release reset; assertion stays asynchronous
  reset_sync u_rst (
    .clk(CLK),
    .rst_in_n(RST_N),
    .rst_out_n(rst_n)
  );

  // ----------------------------------------
  // clock-state sequencer
  // ----------------------------------------
  // one-hot states; TW repeats while ready is low
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_T1 = 5'h02,
    ST_T2 = 5'h04,
    ST_TW = 5'h08,
    ST_T3 = 5'h10
  } state_t;

  state_t state;
  state_t next_state;
  cycle_req_t cur;
  logic [2:0] code;

  // ----------------------------------------
  // cycle start decode
  // ----------------------------------------
  wire parked = HOLD_MODE | HALT_MODE;
  wire start = (state == ST_IDLE || state == ST_T3) && REQ_VALID && !parked;
  wire is_write = !code[STATUS1_BIT];
  // opcode fetch and interrupt acknowledge never wait on ready
  wire is_rw = (code != CODE_INT_ACK) && (code != CODE_OPFETCH);
  wire wait_now = is_rw && !READY;
  // last data clock of the cycle: ready seen, or no ready needed
  wire finish = (state == ST_T2 || state == ST_TW) && !wait_now; // R18
  wire [7:0] next_rdata = is_write ? BYTE_RESET : SHARED_LOW_ADDR_DATA_IN;

  // ----------------------------------------
  // next-state decode
  // ----------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: next_state = start ? ST_T1 : ST_IDLE;
      ST_T1: next_state = ST_T2;
      ST_T2: next_state = wait_now ? ST_TW : ST_T3; // R19
      ST_TW: next_state = wait_now ? ST_TW : ST_T3; // R18
      ST_T3: next_state = start ? ST_T1 : ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // request capture, held for the whole cycle
  // ----------------------------------------
  // the request is copied at start so REQ may change freely mid-cycle
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      cur <= '0;
    end else if (start) begin
      cur <= REQ;
    end
  end

  // status code is frozen from T1 to the end of T3
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      code <= CODE_OPFETCH;
    end else if (start) begin
      code <= REQ.kind; // R13
    end
  end

  // ----------------------------------------
  // pin values, all registered
  // ----------------------------------------
  // every pin is computed from the next state and registered, so each
  // pin changes on the same edge as the state it belongs to
  wire in_t1 = (next_state == ST_T1);
  wire active = (next_state != ST_IDLE);
  wire data_phase = (next_state == ST_T2) || (next_state == ST_TW);
  wire [2:0] next_code = start ? REQ.kind : code;
  cycle_req_t next_cur;
  assign next_cur = start ? REQ : cur;

  // ----------------------------------------
  // address and data pins
  // ----------------------------------------
  wire next_write = !next_code[STATUS1_BIT];
  wire io_cycle = next_code[SELECT_BIT];
  wire [7:0] next_high =
    io_cycle ? next_cur.addr[7:0] : next_cur.addr[15:8]; // R1
  wire next_low_oe = in_t1 || (active && next_write); // R4
  wire [7:0] next_low =
    in_t1 ? next_cur.addr[7:0] : next_cur.wdata; // R3 R16

  // ----------------------------------------
  // strobe pins
  // ----------------------------------------
  // hold and halt take the pins away at once, even inside a cycle;
  // the sequencer runs on so a cycle under way is not lost
  wire next_drive = !HOLD_MODE && !HALT_MODE; // R2
  wire next_rd_n = !(data_phase && !next_write); // R14
  wire next_wr_n = !(data_phase && next_write); // R15

  // ----------------------------------------
  // status pins
  // ----------------------------------------
  logic [1:0] next_status;
  always_comb begin
    if (HALT_MODE && !HOLD_MODE) begin
      next_status = CODE_HALT_STATUS; // R11
    end else begin
      next_status = next_code[1:0]; // R8 R9 R10 R12
    end
  end

  // ----------------------------------------
  // three-state pin registers
  // ----------------------------------------
  // enables reset low so no three-state pin drives the bus while reset holds
  tri_out #(.WIDTH(8)) u_high (
    .clk(CLK),
    .rst_n(rst_n),
    .next_value(next_high),
    .next_enable(next_drive), // R2
    .value(HIGH_ADDRESS_BYTE),
    .enable(HIGH_ADDRESS_BYTE_OE)
  );

  tri_out #(.WIDTH(8)) u_low (
    .clk(CLK),
    .rst_n(rst_n),
    .next_value(next_low),
    .next_enable(next_low_oe && next_drive),
    .value(SHARED_LOW_ADDR_DATA_OUT),
    .enable(SHARED_LOW_ADDR_DATA_OE)
  );

  tri_out #(.WIDTH(1)) u_sel (
    .clk(CLK),
    .rst_n(rst_n),
    .next_value(next_code[SELECT_BIT]),
    .next_enable(next_drive), // R11
    .value(MEM_IO_SELECT),
    .enable(MEM_IO_SELECT_OE)
  );

  // ----------------------------------------
  // address latch strobe, never floated
  // ----------------------------------------
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      ADDR_LATCH_STROBE <= 1'b0; // R6
    end else begin
      ADDR_LATCH_STROBE <= in_t1; // R5 R6
    end
  end

  // ----------------------------------------
  // cycle status, always driven
  // ----------------------------------------
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      CYCLE_STATUS_BIT1 <= 1'b0;
    end else begin
      CYCLE_STATUS_BIT1 <= next_status[1]; // R12
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      CYCLE_STATUS_BIT0 <= 1'b0;
    end else begin
      CYCLE_STATUS_BIT0 <= next_status[0];
    end
  end

  // ----------------------------------------
  // read and write strobes
  // ----------------------------------------
  // low through T2 and every wait clock, high again in T3
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      READ_STROBE_N <= 1'b1;
    end else begin
      READ_STROBE_N <= next_rd_n; // R14
    end
  end

  // rises into T3 while the data pins still hold the write data
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      WRITE_STROBE_N <= 1'b1;
    end else begin
      WRITE_STROBE_N <= next_wr_n; // R16
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      STROBES_OE <= 1'b0;
    end else begin
      STROBES_OE <= next_drive; // R2
    end
  end

  // ----------------------------------------
  // request and completion handshake
  // ----------------------------------------
  // one-clock pulse: the request was taken on the previous edge
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      REQ_READY <= 1'b0;
    end else begin
      REQ_READY <= start;
    end
  end

  // one-clock pulse after the last data clock
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      DONE_VALID <= 1'b0;
    end else begin
      DONE_VALID <= finish; // R18
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      DONE <= '0;
    end else if (finish) begin
      // read data is taken on the edge that leaves the last data clock
      DONE.rdata <= next_rdata; // R4 R14
      DONE.kind <= code;
    end
  end
endmodule : bus_cycle
`default_nettype wire

/* dv/bus_cycle_chk.sv */
`timescale 1ns/1ns
`default_nettype none
module bus_cycle_chk (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic HALT_MODE,
  input wire logic READY,
  input wire logic [7:0] HIGH_ADDRESS_BYTE,
  input wire logic HIGH_ADDRESS_BYTE_OE,
  input wire logic [7:0] SHARED_LOW_ADDR_DATA_OUT,
  input wire logic SHARED_LOW_ADDR_DATA_OE,
  input wire logic ADDR_LATCH_STROBE,
  input wire logic MEM_IO_SELECT,
  input wire logic MEM_IO_SELECT_OE,
  input wire logic CYCLE_STATUS_BIT1,
  input wire logic CYCLE_STATUS_BIT0,
  input wire logic READ_STROBE_N,
  input wire logic WRITE_STROBE_N,
  input wire logic STROBES_OE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  wire logic rd = STROBES_OE && !READ_STROBE_N;
  wire logic wr = STROBES_OE && !WRITE_STROBE_N;
  wire logic xfer = CYCLE_STATUS_BIT1 != CYCLE_STATUS_BIT0;
  sequence s_stall;
    (rd || wr) && xfer && !READY;
  endsequence
  chk_ale_pulse: assert property (
    $rose(ADDR_LATCH_STROBE) |=> !ADDR_LATCH_STROBE) else $error("ale width");
  chk_ale_addr: assert property (
    ADDR_LATCH_STROBE |-> SHARED_LOW_ADDR_DATA_OE && !rd && !wr)
    else $error("address phase");
  chk_read_free: assert property (
    rd |-> !SHARED_LOW_ADDR_DATA_OE && !wr) else $error("read drive");
  chk_write_drive: assert property (
    wr |-> SHARED_LOW_ADDR_DATA_OE) else $error("write data off");
  chk_write_hold: assert property (
    STROBES_OE && $rose(WRITE_STROBE_N) |-> SHARED_LOW_ADDR_DATA_OE &&
    $stable(SHARED_LOW_ADDR_DATA_OUT)) else $error("write data lost");
  chk_wait_hold: assert property (
    s_stall |=> (rd || wr) && $stable(HIGH_ADDRESS_BYTE) &&
    $stable(SHARED_LOW_ADDR_DATA_OUT)) else $error("wait state");
  chk_status_hold: assert property (
    rd || wr |-> $stable({MEM_IO_SELECT, CYCLE_STATUS_BIT1,
    CYCLE_STATUS_BIT0})) else $error("status moved");
  chk_halt_float: assert property (
    HALT_MODE[*8] |-> !HIGH_ADDRESS_BYTE_OE && !STROBES_OE &&
    !MEM_IO_SELECT_OE && !CYCLE_STATUS_BIT1 && !CYCLE_STATUS_BIT0)
    else $error("halt float");
endmodule : bus_cycle_chk
bind bus_cycle bus_cycle_chk bus_cycle_chk_i (.CLK, .RST_N, .HALT_MODE,
  .READY, .HIGH_ADDRESS_BYTE, .HIGH_ADDRESS_BYTE_OE,
  .SHARED_LOW_ADDR_DATA_OUT, .SHARED_LOW_ADDR_DATA_OE,
  .ADDR_LATCH_STROBE, .MEM_IO_SELECT, .MEM_IO_SELECT_OE,
  .CYCLE_STATUS_BIT1, .CYCLE_STATUS_BIT0, .READ_STROBE_N,
  .WRITE_STROBE_N, .STROBES_OE);
`default_nettype wire

/* dv/bus_mem_model.sv */
`timescale 1ns/1ns
`default_nettype none
module bus_mem_model (
  input wire logic clk,
  input wire logic [3:0] waits,
  input wire logic [7:0] hi,
  input wire logic [7:0] ad,
  input wire logic ale,
  input wire logic sel,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic oe,
  output logic ready,
  output logic [7:0] dout,
  output logic dout_oe
);
  logic [7:0] mem [0:131071];
  logic [7:0] lo = 8'h00;
  logic [3:0] cnt = 4'h0;
  wire logic act = oe && !(rd_n && wr_n);
  wire logic [16:0] key = {sel, hi, lo};
  assign ready = !(act && cnt < waits);
  assign dout_oe = oe && !rd_n;
  assign dout = mem[key];
  always @(posedge clk) begin
    cnt <= act ? cnt + 4'h1 : 4'h0;
    if (ale) lo <= ad;
  end
  // write data taken on the trailing edge of the strobe
  always @(posedge wr_n) if (oe) mem[key] <= ad;
endmodule : bus_mem_model
`default_nettype wire

/* dv/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import bus_cycle_pkg::*;
  logic CLK = 1'b0;
  logic RST_N = 1'b0;
  logic HOLD_MODE = 1'b0;
  logic HALT_MODE = 1'b0;
  logic REQ_VALID = 1'b0;
  cycle_req_t REQ = '0;
  logic [3:0] waits = 4'h0;
  logic [7:0] last_ad = 8'h00;
  int n_mismatch = 0;
  int cmp_count = 0;
  wire cycle_done_t DONE;
  wire logic [7:0] HIGH_ADDRESS_BYTE, SHARED_LOW_ADDR_DATA_OUT, mdout;
  wire logic [7:0] SHARED_LOW_ADDR_DATA_IN;
  wire logic REQ_READY, DONE_VALID, READY, HIGH_ADDRESS_BYTE_OE, mdoe;
  wire logic SHARED_LOW_ADDR_DATA_OE, ADDR_LATCH_STROBE, MEM_IO_SELECT;
  wire logic MEM_IO_SELECT_OE, CYCLE_STATUS_BIT1, CYCLE_STATUS_BIT0;
  wire logic READ_STROBE_N, WRITE_STROBE_N, STROBES_OE;
  // released bus shows a changing pattern
  assign SHARED_LOW_ADDR_DATA_IN = SHARED_LOW_ADDR_DATA_OE ?
    SHARED_LOW_ADDR_DATA_OUT : mdoe ? mdout : ~last_ad;
  always @(posedge CLK) last_ad <= SHARED_LOW_ADDR_DATA_IN;
  always #25 CLK = ~CLK;
  bus_cycle bus_cycle_i (.CLK, .RST_N, .HOLD_MODE, .HALT_MODE, .REQ_VALID,
    .REQ, .REQ_READY, .DONE_VALID, .DONE, .READY, .HIGH_ADDRESS_BYTE,
    .HIGH_ADDRESS_BYTE_OE, .SHARED_LOW_ADDR_DATA_IN,
    .SHARED_LOW_ADDR_DATA_OUT, .SHARED_LOW_ADDR_DATA_OE,
    .ADDR_LATCH_STROBE, .MEM_IO_SELECT, .MEM_IO_SELECT_OE,
    .CYCLE_STATUS_BIT1, .CYCLE_STATUS_BIT0, .READ_STROBE_N,
    .WRITE_STROBE_N, .STROBES_OE);
  bus_mem_model bus_mem_model_i (.clk(CLK), .waits, .hi(HIGH_ADDRESS_BYTE),
    .ad(SHARED_LOW_ADDR_DATA_IN), .ale(ADDR_LATCH_STROBE),
    .sel(MEM_IO_SELECT), .rd_n(READ_STROBE_N), .wr_n(WRITE_STROBE_N),
    .oe(STROBES_OE), .ready(READY), .dout(mdout), .dout_oe(mdoe));
  task summarize;
    if (n_mismatch == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize
  task chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task wait_for(input bit done);
    int i;
    for (i = 0; i < 40 && (done ? DONE_VALID : REQ_READY) !== 1'b1; i++)
      @(negedge CLK);
    if (i == 40) begin
      n_mismatch++;
      summarize();
    end
  endtask : wait_for
  task run(input cycle_kind_t k, input logic [15:0] a, input logic [7:0] d);
    REQ_VALID = 1'b1;
    REQ = '{k, a, d};
    wait_for(1'b0);
    REQ_VALID = 1'b0;
    chk({HIGH_ADDRESS_BYTE, SHARED_LOW_ADDR_DATA_OUT}, a);
    chk(16'({ADDR_LATCH_STROBE, MEM_IO_SELECT, CYCLE_STATUS_BIT1,
      CYCLE_STATUS_BIT0}), 16'({1'b1, k}));
    wait_for(1'b1);
    if (k[1] && k != KIND_INT_ACK) chk(16'(DONE.rdata), 16'(d));
    chk(16'(DONE.kind), 16'(k));
  endtask : run
  task t_kinds;
    run(KIND_MEM_WRITE, 16'h12A5, 8'h3C);
    run(KIND_IO_WRITE, 16'h4747, 8'hC3);
    run(KIND_MEM_READ, 16'h12A5, 8'h3C);
    run(KIND_IO_READ, 16'h4747, 8'hC3);
    run(KIND_OPFETCH, 16'h12A5, 8'h3C);
    run(KIND_INT_ACK, 16'h4747, 8'h00);
  endtask : t_kinds
  task t_waits;
    waits = 4'h3;
    run(KIND_MEM_WRITE, 16'hFF00, 8'h5A);
    run(KIND_MEM_READ, 16'hFF00, 8'h5A);
    waits = 4'h0;
  endtask : t_waits
  task t_float(input logic h);
    HOLD_MODE = h;
    HALT_MODE = !h;
    REQ_VALID = 1'b1;
    repeat (10) @(negedge CLK);
    chk(16'({REQ_READY, HIGH_ADDRESS_BYTE_OE, STROBES_OE,
      MEM_IO_SELECT_OE}), 16'h0000);
    if (!h) chk(16'({CYCLE_STATUS_BIT1, CYCLE_STATUS_BIT0}), 16'h0000);
    HOLD_MODE = 1'b0;
    HALT_MODE = 1'b0;
    run(KIND_MEM_READ, 16'h12A5, 8'h3C);
  endtask : t_float
  initial begin
    repeat (12) @(negedge CLK);
    chk(16'({HIGH_ADDRESS_BYTE_OE, STROBES_OE, ADDR_LATCH_STROBE}),
      16'h0000);
    RST_N = 1'b1;
    repeat (3) @(negedge CLK);
    t_kinds();
    t_waits();
    t_float(1'b1);
    t_float(1'b0);
    summarize();
  end
endmodule : tb_top
`default_nettype wire
